// *** rtl/hfwba_bank.v ***
// hop tuning word bank a with apb slave and phase accumulator
//
// Overview of operation
// - sixteen words, index n at base plus 4n
// - frequency equals word times 2^-32 times rate
// - modulo 2^32 accumulation, signed or unsigned
// - word change after sync loses phase determinism
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hfwba_defs.vh"
module hfwba_bank
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sample_enable,
  input wire sync_event,
  output reg [31:0] phase_accum,
  output reg [31:0] tuning_value_a,
  output reg [3:0] hop_select_index_a_out
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [31:0] hop_tuning_word_a_reg [0:15];
  reg oscillator_enable_reg;
  reg change_block_reg;
  reg [3:0] hop_select_index_a_reg;
  reg synced_reg;
  reg nondet_reg;
  reg [31:0] acc_reg;
  integer i;

  wire in_bank = (paddr >= `HFWBA_BANK_BASE) && (paddr <= `HFWBA_BANK_LAST)
    && (paddr[1:0] == 2'b00);
  wire [11:0] bank_off = paddr - `HFWBA_BANK_BASE;
  wire [3:0] bank_idx = bank_off[5:2];
  wire is_ctrl = (paddr == `HFWBA_CTRL_ADDR);
  wire is_stat = (paddr == `HFWBA_STAT_ADDR);
  wire is_phase = (paddr == `HFWBA_PHASE_ADDR);
  wire mapped = in_bank | is_ctrl | is_stat | is_phase;
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite & mapped & ~pslverr;
  wire unsafe = oscillator_enable_reg & ~change_block_reg;
  wire sync_now = sync_event | (wr & is_ctrl & pwdata[`HFWBA_CTRL_SYNC_BIT]);
  wire [31:0] sel_word = hop_tuning_word_a_reg[hop_select_index_a_reg];

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] st;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
      begin
        merge[b*8 +: 8] = st[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // apb slave: no wait states, answer in the cycle after setup
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup & ~pwrite)
      begin
        if (in_bank)
          prdata <= hop_tuning_word_a_reg[bank_idx];
        else if (is_ctrl)
          prdata <= {24'h000000, hop_select_index_a_reg, 1'b0, 1'b0,
            change_block_reg, oscillator_enable_reg};
        else if (is_stat)
          prdata <= {20'h00000, hop_select_index_a_reg, 5'h00, nondet_reg,
            unsafe, synced_reg};
        else if (is_phase)
          prdata <= acc_reg;
        else
          prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < `HFWBA_BANK_WORDS; i = i + 1)
        hop_tuning_word_a_reg[i] <= `HFWBA_WORD_RESET;
      oscillator_enable_reg <= 1'b0;
      change_block_reg <= 1'b0;
      hop_select_index_a_reg <= 4'h0;
    end
    else if (wr)
    begin
      if (in_bank)
        hop_tuning_word_a_reg[bank_idx] <= merge(hop_tuning_word_a_reg[bank_idx],
          pwdata, pstrb);
      if (is_ctrl & pstrb[0])
      begin
        oscillator_enable_reg <= pwdata[`HFWBA_CTRL_EN_BIT];
        change_block_reg <= pwdata[`HFWBA_CTRL_BLK_BIT];
        hop_select_index_a_reg <= pwdata[`HFWBA_CTRL_SEL_MSB:`HFWBA_CTRL_SEL_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // sync tracking: word write after sync marks phase non-deterministic
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      synced_reg <= 1'b0;
      nondet_reg <= 1'b0;
    end
    else if (sync_now)
    begin
      synced_reg <= 1'b1;
      nondet_reg <= 1'b0;
    end
    else if (wr & in_bank & synced_reg)
      nondet_reg <= 1'b1;
  end

  // ----------------------------------------------------------------
  // phase accumulator, wraps modulo 2^32
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_reg <= 32'h00000000;
    else if (sync_now | ~oscillator_enable_reg)
      acc_reg <= 32'h00000000;
    else if (sample_enable)
      acc_reg <= acc_reg + sel_word;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_accum <= 32'h00000000;
      tuning_value_a <= 32'h00000000;
      hop_select_index_a_out <= 4'h0;
    end
    else
    begin
      phase_accum <= acc_reg;
      tuning_value_a <= sel_word;
      hop_select_index_a_out <= hop_select_index_a_reg;
    end
  end
endmodule // hfwba_bank
`default_nettype wire

// *** rtl/hfwba_defs.vh ***
// constants for the hop tuning word bank a
`ifndef HFWBA_DEFS_VH
`define HFWBA_DEFS_VH
`define HFWBA_BANK_BASE 12'h400
`define HFWBA_BANK_WORDS 16
`define HFWBA_BANK_LAST 12'h43c
`define HFWBA_CTRL_ADDR 12'h500
`define HFWBA_STAT_ADDR 12'h504
`define HFWBA_PHASE_ADDR 12'h508
`define HFWBA_CTRL_EN_BIT 0
`define HFWBA_CTRL_BLK_BIT 1
`define HFWBA_CTRL_SYNC_BIT 2
`define HFWBA_CTRL_SEL_LSB 4
`define HFWBA_CTRL_SEL_MSB 7
`define HFWBA_CTRL_RESET 32'h00000000
`define HFWBA_WORD_RESET 32'h00000000
`define HFWBA_STAT_SYNCED_BIT 0
`define HFWBA_STAT_UNSAFE_BIT 1
`define HFWBA_STAT_NONDET_BIT 2
`define HFWBA_SEL_LSB 8
`define HFWBA_SEL_MSB 11
`endif

// *** verif/hfwba_asserts.sv ***
// checker for the hop word bank
`timescale 1ns/1ps
`default_nettype none
module hfwba_asserts
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] tuning_value_a,
  input wire logic sample_enable,
  input wire logic sync_event,
  input wire logic [31:0] phase_accum
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_hold;
    !sample_enable && !sync_event && !psel && !$past(psel) |=> ##1 $stable(phase_accum);
  endproperty
  a_hold: assert property (p_hold) else $error("phase moved");
  property p_sync;
    sync_event |=> ##1 phase_accum == 32'h0;
  endproperty
  a_sync: assert property (p_sync) else $error("sync missed");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_word_hold;
    !psel && !$past(psel) |=> $stable(tuning_value_a);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved");
  property p_accum_add;
    sample_enable && !sync_event && !psel && !$past(psel) |=> ##1
      ((phase_accum == $past(phase_accum) + $past(tuning_value_a)) || (phase_accum == 32'h0));
  endproperty
  a_accum_add: assert property (p_accum_add) else $error("bad phase step");
endmodule // hfwba_asserts
bind hfwba_bank hfwba_asserts u_chk (.pclk, .presetn, .psel, .pready, .pslverr,
  .tuning_value_a, .sample_enable, .sync_event, .phase_accum);
`default_nettype wire

// *** verif/hop_freq_word_bank_a_tb_top.sv ***
// bench for the hop word bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("Error %0t %h", $time, a); end end
module hop_freq_word_bank_a_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready;
  logic sample_enable = 0, sync_event = 0, pslverr;
  logic [3:0] pstrb = 4'hf, hop_select_index_a_out;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, phase_accum, tuning_value_a;
  int n_fail = 0, n_checks = 0, cyc = 0;
  always #2 pclk = ~pclk;
  hfwba_bank uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sample_enable, .sync_event, .phase_accum, .tuning_value_a,
    .hop_select_index_a_out);
  task final_report;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk)
    if (++cyc > 1000)
    begin
      n_fail++;
      final_report;
    end
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    `CHK(prdata, e)
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rchk(12'h43c, 32'h0);
    xfer(1, 12'h43c, 32'hc000_0000);
    rchk(12'h43c, 32'hc000_0000);
    $display("bank done");
    xfer(1, 12'h500, 32'hf3);
    @(posedge pclk);
    sync_event <= 1;
    @(posedge pclk);
    sync_event <= 0;
    `CHK(tuning_value_a, 32'hc000_0000)
    sample_enable <= 1;
    repeat (3) @(posedge pclk);
    sample_enable <= 0;
    rchk(12'h508, 32'h4000_0000);
    `CHK(phase_accum, 32'h4000_0000)
    rchk(12'h504, 32'h0f01);
    xfer(1, 12'h404, 32'h1);
    rchk(12'h504, 32'h0f05);
    xfer(1, 12'h500, 32'hf7);
    rchk(12'h504, 32'h0f01);
    xfer(1, 12'h500, 32'h01);
    rchk(12'h504, 32'h0003);
    `CHK(hop_select_index_a_out, 4'h0)
    pstrb <= 4'h1;
    xfer(1, 12'h400, 32'h1234_5678);
    pstrb <= 4'hf;
    rchk(12'h400, 32'h78);
    xfer(0, 12'h600, 0);
    `CHK(pslverr, 1'b1)
    `CHK(prdata, 32'h0)
    $display("phase done");
    final_report;
  end
endmodule // hop_freq_word_bank_a_tb_top
`default_nettype wire
